//--- common/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    // register byte offsets on the bus
    localparam logic [4:0] OSC_CONTROL_REG_OFS = 5'h00;
    localparam logic [4:0] CLOCK_DIVISOR_CTRL_OFS = 5'h04;
    localparam logic [4:0] PLL_FEEDBACK_DIVISOR_OFS = 5'h08;
    localparam logic [4:0] RC_OSC_TUNING_OFS = 5'h0C;
    localparam logic [4:0] LOCK_CYCLES_OFS = 5'h10;
    // field positions
    localparam int CUR_SRC_LSB = 0;
    localparam int LOCK_BIT = 5;
    localparam int NEXT_SRC_LSB = 8;
    localparam int SWITCH_GO_BIT = 15;
    localparam int PLL_IN_DIV_LSB = 0;
    localparam int PLL_OUT_DIV_LSB = 6;
    localparam int RC_POSTSCALE_LSB = 8;
    // reset values
    localparam logic [4:0] PLL_IN_DIV_RST = 5'h00;
    localparam logic [1:0] PLL_OUT_DIV_RST = 2'h1;
    localparam logic [8:0] PLL_FEEDBACK_RST = 9'h030;
    localparam logic [2:0] RC_POSTSCALE_RST = 3'h0;
    localparam logic [5:0] RC_TRIM_RST = 6'h00;
    localparam logic [15:0] LOCK_CYCLES_RST = 16'h0100;
    // ratio offsets, fixed ratio and last startup count
    localparam logic [8:0] DIV_PLUS = 9'h002;
    localparam logic [8:0] RC_DIV16_RATIO = 9'h010;
    localparam logic [9:0] STARTUP_LAST = 10'h3FF;
    // axi answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // source selection codes
    localparam logic [2:0] SRC_RC = 3'h0;
    localparam logic [2:0] SRC_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_RC_DIVN = 3'h7;
endpackage

//--- rtl/rc_osc_postscaler_pll_ctrl.sv
// What this block does
// - software trims rc oscillator with six-bit field
// - rc clock usable at once, no startup count
// - decode power-on source codes 111,110,001,000
// - rc postscaler: 1,2,4..64, code 111 is 256
// - postscaled rc may feed the pll input
// - input ratio is field bits 4:0 plus two
// - feedback ratio is nine-bit field plus two
// - output ratio is twice field bits 7:6 plus one
// - system clock is input times feedback over ratios
// - reset loads input 00, output 01, feedback 0x30
// - lock interval restarts on input change or input/feedback divisor change
// - lock interval begins once pll input is valid
// - read-only lock bit, cleared at reset and switch
// - lock bit stays clear on non-pll sources
// - primary clock held for 1024 startup cycles
`timescale 1ns/100ps
module rc_osc_postscaler_pll_ctrl
    import clk_ctrl_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // oscillator events and power-on strap
    input wire logic RC_TICK,
    input wire logic PRI_TICK,
    input wire logic VCO_TICK,
    input wire logic [2:0] INIT_SRC,
    // clock outputs as enables
    output logic SYS_TICK,
    output logic PLL_REF_TICK,
    // analog controls and status
    output logic [5:0] RC_TRIM,
    output logic [8:0] PLL_FB_FIELD,
    output logic PLL_LOCKED,
    output logic [2:0] CUR_SOURCE,
    // axi4-lite write
    input wire logic [4:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [4:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    // whole state of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic strap_taken;
        logic [2:0] osc_sel;
        logic [2:0] next_src;
        logic [4:0] pre;
        logic [1:0] post;
        logic [2:0] rcdiv;
        logic [8:0] fbd;
        logic [5:0] trim;
        logic [15:0] lock_lim;
        logic lock;
        logic [15:0] lock_cnt;
        logic [9:0] ost_cnt;
        logic ost_done;
        logic [8:0] rc_cnt;
        logic [8:0] rc_ratio;
        logic [8:0] pre_cnt;
        logic [8:0] pre_ratio;
        logic [8:0] vco_cnt;
        logic [8:0] vco_ratio;
        logic sys_tick;
        logic ref_tick;
    } state_t;

    state_t st_reg; // registered state
    state_t st_next; // next state

    // one divider step; ratio reloads only when a period ends
    function automatic logic [18:0] div_step(input logic [8:0] cnt, input logic [8:0] ratio,
        input logic tick, input logic [8:0] new_ratio);
        logic [8:0] inc;
        inc = cnt + 9'h001;
        if (!tick)
        begin
            div_step = {1'b0, cnt, ratio};
        end
        else if (inc >= ratio)
        begin
            div_step = {1'b1, 9'h000, new_ratio};
        end
        else
        begin
            div_step = {1'b0, inc, ratio};
        end
    endfunction

    // rc postscaler code to ratio
    function automatic logic [8:0] rc_ratio_of(input logic [2:0] code);
        if (code == 3'h7)
        begin
            rc_ratio_of = 9'h100;
        end
        else
        begin
            rc_ratio_of = 9'h001 << code;
        end
    endfunction

    // sources that route through the pll
    function automatic logic is_pll(input logic [2:0] src);
        is_pll = (src == SRC_RC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    // only documented codes are accepted
    function automatic logic src_legal(input logic [2:0] src);
        src_legal = (src <= SRC_PRI_PLL) || (src >= SRC_RC_DIV16);
    endfunction

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // register views for readback and merge
    logic [31:0] osc_view;
    logic [31:0] div_view;
    assign osc_view = {16'h0000, 5'h00, st_reg.next_src, 2'h0, st_reg.lock, 2'h0,
        st_reg.osc_sel};
    assign div_view = {16'h0000, 5'h00, st_reg.rcdiv, st_reg.post, 1'b0, st_reg.pre};

    // next-state logic
    always_comb
    begin
        logic [18:0] rc_step;
        logic [18:0] pre_step;
        logic [18:0] vco_step;
        logic [31:0] wv;
        logic pri_sel;
        logic pri_ok;
        logic pll_in;
        logic pll_in_ok;
        logic do_wr;
        logic restart;
        rc_step = '0;
        pre_step = '0;
        vco_step = '0;
        wv = '0;
        restart = 1'b0;
        pri_sel = 1'b0;
        pri_ok = 1'b0;
        pll_in = 1'b0;
        pll_in_ok = 1'b0;
        do_wr = 1'b0;
        st_next = st_reg;
        st_next.sys_tick = 1'b0;
        st_next.ref_tick = 1'b0;
        // power-on strap is caught on the first cycle out of reset
        if (!st_reg.strap_taken)
        begin
            st_next.strap_taken = 1'b1;
            st_next.osc_sel = src_legal(INIT_SRC) ? INIT_SRC : SRC_RC;
        end
        // primary startup timer, restarted whenever primary is dropped
        pri_sel = (st_reg.osc_sel == SRC_PRI) || (st_reg.osc_sel == SRC_PRI_PLL);
        if (!pri_sel)
        begin
            st_next.ost_cnt = 10'h000;
            st_next.ost_done = 1'b0;
        end
        else if (PRI_TICK && !st_reg.ost_done)
        begin
            st_next.ost_cnt = st_reg.ost_cnt + 10'h001;
            st_next.ost_done = (st_reg.ost_cnt == STARTUP_LAST);
        end
        pri_ok = PRI_TICK && st_reg.ost_done;
        // rc postscaler, forced to sixteen in the fixed mode
        rc_step = div_step(st_reg.rc_cnt, st_reg.rc_ratio, RC_TICK,
            (st_reg.osc_sel == SRC_RC_DIV16) ? RC_DIV16_RATIO : rc_ratio_of(st_reg.rcdiv));
        st_next.rc_cnt = rc_step[17:9];
        st_next.rc_ratio = rc_step[8:0];
        // strap mode gets its own ratio at once, so no short first period
        if (!st_reg.strap_taken)
        begin
            st_next.rc_cnt = 9'h000;
            st_next.rc_ratio = (INIT_SRC == SRC_RC_DIV16) ? RC_DIV16_RATIO
                : rc_ratio_of(st_reg.rcdiv);
        end
        // pll input: postscaled rc or released primary
        pll_in = (st_reg.osc_sel == SRC_RC_PLL) ? rc_step[18] : pri_ok;
        pll_in_ok = (st_reg.osc_sel == SRC_RC_PLL) || st_reg.ost_done;
        // phase detector reference, ratio field plus two
        pre_step = div_step(st_reg.pre_cnt, st_reg.pre_ratio, pll_in && is_pll(st_reg.osc_sel),
            {4'h0, st_reg.pre} + DIV_PLUS);
        st_next.pre_cnt = pre_step[17:9];
        st_next.pre_ratio = pre_step[8:0];
        st_next.ref_tick = pre_step[18];
        // pll output divider, twice field plus one
        vco_step = div_step(st_reg.vco_cnt, st_reg.vco_ratio, VCO_TICK,
            {6'h00, st_reg.post, 1'b0} + 9'h002);
        st_next.vco_cnt = vco_step[17:9];
        st_next.vco_ratio = vco_step[8:0];
        // system clock selection; the rc path has no startup hold
        unique case (st_reg.osc_sel)
            SRC_RC: st_next.sys_tick = RC_TICK;
            SRC_RC_DIV16, SRC_RC_DIVN: st_next.sys_tick = rc_step[18];
            SRC_PRI: st_next.sys_tick = pri_ok;
            SRC_RC_PLL, SRC_PRI_PLL: st_next.sys_tick = vco_step[18];
            default: st_next.sys_tick = 1'b0;
        endcase
        // write channel: address and data taken together in one handshake
        st_next.awready = 1'b0;
        st_next.wready = 1'b0;
        do_wr = st_reg.awready && AWVALID && st_reg.wready && WVALID;
        if (st_reg.bvalid && BREADY)
        begin
            st_next.bvalid = 1'b0;
        end
        if (AWVALID && WVALID && !st_reg.bvalid && !st_reg.awready)
        begin
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        if (do_wr)
        begin
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (AWADDR)
                OSC_CONTROL_REG_OFS:
                begin
                    wv = merge(osc_view, WDATA, WSTRB);
                    st_next.next_src = wv[NEXT_SRC_LSB +: 3];
                    // switch request; illegal codes leave the source alone
                    if (wv[SWITCH_GO_BIT] && src_legal(wv[NEXT_SRC_LSB +: 3]))
                    begin
                        st_next.osc_sel = wv[NEXT_SRC_LSB +: 3];
                        restart = 1'b1;
                    end
                end
                CLOCK_DIVISOR_CTRL_OFS:
                begin
                    wv = merge(div_view, WDATA, WSTRB);
                    st_next.pre = wv[PLL_IN_DIV_LSB +: 5];
                    st_next.post = wv[PLL_OUT_DIV_LSB +: 2];
                    st_next.rcdiv = wv[RC_POSTSCALE_LSB +: 3];
                    // a new rc postscale changes the pll input when rc feeds it
                    restart = (st_next.pre != st_reg.pre) || ((st_next.rcdiv != st_reg.rcdiv)
                        && (st_reg.osc_sel == SRC_RC_PLL));
                end
                PLL_FEEDBACK_DIVISOR_OFS:
                begin
                    wv = merge({23'h0, st_reg.fbd}, WDATA, WSTRB);
                    st_next.fbd = wv[8:0];
                    restart = (wv[8:0] != st_reg.fbd);
                end
                RC_OSC_TUNING_OFS:
                begin
                    wv = merge({26'h0, st_reg.trim}, WDATA, WSTRB);
                    st_next.trim = wv[5:0];
                end
                LOCK_CYCLES_OFS:
                begin
                    wv = merge({16'h0, st_reg.lock_lim}, WDATA, WSTRB);
                    st_next.lock_lim = wv[15:0];
                end
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        // lock model: counts only while a pll source has a live input
        if (!is_pll(st_next.osc_sel) || restart || !st_reg.strap_taken)
        begin
            st_next.lock = 1'b0;
            st_next.lock_cnt = 16'h0000;
        end
        else if (pll_in_ok && !st_reg.lock)
        begin
            st_next.lock_cnt = st_reg.lock_cnt + 16'h0001;
            st_next.lock = (st_reg.lock_cnt >= st_reg.lock_lim);
        end
        // read channel, data captured at the address handshake
        st_next.arready = 1'b0;
        if (st_reg.rvalid && RREADY)
        begin
            st_next.rvalid = 1'b0;
        end
        if (ARVALID && !st_reg.rvalid && !st_reg.arready)
        begin
            st_next.arready = 1'b1;
        end
        if (st_reg.arready && ARVALID)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            unique case (ARADDR)
                OSC_CONTROL_REG_OFS: st_next.rdata = osc_view;
                CLOCK_DIVISOR_CTRL_OFS: st_next.rdata = div_view;
                PLL_FEEDBACK_DIVISOR_OFS: st_next.rdata = {23'h0, st_reg.fbd};
                RC_OSC_TUNING_OFS: st_next.rdata = {26'h0, st_reg.trim};
                LOCK_CYCLES_OFS: st_next.rdata = {16'h0, st_reg.lock_lim};
                default:
                begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // state register; divider fields take their power-on defaults
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            st_reg <= '0;
            st_reg.pre <= PLL_IN_DIV_RST;
            st_reg.post <= PLL_OUT_DIV_RST;
            st_reg.fbd <= PLL_FEEDBACK_RST;
            st_reg.rcdiv <= RC_POSTSCALE_RST;
            st_reg.trim <= RC_TRIM_RST;
            st_reg.lock_lim <= LOCK_CYCLES_RST;
            st_reg.rc_ratio <= 9'h001;
            st_reg.pre_ratio <= DIV_PLUS;
            st_reg.vco_ratio <= 9'h004;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign SYS_TICK = st_reg.sys_tick;
    assign PLL_REF_TICK = st_reg.ref_tick;
    assign RC_TRIM = st_reg.trim;
    assign PLL_FB_FIELD = st_reg.fbd;
    assign PLL_LOCKED = st_reg.lock;
    assign CUR_SOURCE = st_reg.osc_sel;
    assign AWREADY = st_reg.awready;
    assign WREADY = st_reg.wready;
    assign BVALID = st_reg.bvalid;
    assign BRESP = st_reg.bresp;
    assign ARREADY = st_reg.arready;
    assign RVALID = st_reg.rvalid;
    assign RRESP = st_reg.rresp;
    assign RDATA = st_reg.rdata;

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    AST_BYPASS_NO_LOCK: assert property (!is_pll(st_reg.osc_sel) |-> !PLL_LOCKED)
        else $error("lock set on a bypass source");
    AST_POR_DEFAULTS: assert property ($past(!RST_N) |-> st_reg.pre == 5'h00
        && st_reg.post == 2'h1 && st_reg.fbd == 9'h030) else $error("bad divider defaults");
    AST_STARTUP_1024: assert property ($rose(st_reg.ost_done) |-> $past(st_reg.ost_cnt)
        == 10'h3FF && $past(PRI_TICK)) else $error("startup released early");
    AST_RC_AT_ONCE: assert property (st_reg.osc_sel == SRC_RC && RC_TICK |=> SYS_TICK)
        else $error("rc tick not passed");
    AST_LOCK_INTERVAL: assert property ($rose(PLL_LOCKED) |->
        $past(st_reg.lock_cnt) >= $past(st_reg.lock_lim)) else $error("lock too early");
    AST_SWITCH_CLEARS: assert property (st_reg.awready && AWVALID && st_reg.wready && WVALID
        && AWADDR == OSC_CONTROL_REG_OFS && WSTRB[1] && WDATA[SWITCH_GO_BIT]
        && is_pll(WDATA[NEXT_SRC_LSB +: 3]) |=> !PLL_LOCKED) else $error("lock kept on switch");
    AST_RATIO_AT_EDGE: assert property (!$stable(st_reg.rc_ratio) |-> st_reg.rc_cnt == 9'h000)
        else $error("ratio changed mid period");
    AST_OUT_EVEN: assert property (st_reg.vco_ratio[0] == 1'b0 && st_reg.vco_ratio >= 9'h002)
        else $error("odd output ratio");
    AST_PRE_RATIO: assert property (st_reg.pre_ratio >= 9'h002 && st_reg.pre_ratio <= 9'h021)
        else $error("input ratio out of range");
    AST_DIV16: assert property (st_reg.osc_sel == SRC_RC_DIV16 && RC_TICK
        && st_reg.rc_cnt == 9'h000 |=> !SYS_TICK) else $error("div16 passes single tick");

    COV_LOCK: cover property ($rose(PLL_LOCKED));
    COV_OST: cover property ($rose(st_reg.ost_done));
    COV_RD_ERR: cover property (RVALID && RRESP == RESP_SLVERR);
endmodule

//--- tb/tb_rc_osc_postscaler_pll_ctrl.sv
`timescale 1ns/100ps
module tb_rc_osc_postscaler_pll_ctrl
    import clk_ctrl_pkg::*;
;
    // clock, reset, strap
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] init_src = 3'h0;
    // oscillator ticks from the bench
    logic rc_tick = 1'b0, pri_tick = 1'b0, vco_tick = 1'b0;
    // block outputs
    logic sys_tick, pll_ref_tick, pll_locked;
    logic [5:0] rc_trim;
    logic [8:0] pll_fb_field;
    logic [2:0] cur_source;
    // register bus, ready lines held high by the master
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // scoreboard and tick bookkeeping
    int failures = 0, samples_checked = 0;
    logic [31:0] seed = 32'hA2B60A06;
    int cyc = 0, sys_cnt = 0, sys_last = 0, sys_prev = 0, ref_cnt = 0, ref_last = 0, ref_prev = 0;
    bit rc_en = 1'b0, pri_en = 1'b0, vco_en = 1'b0;
    int rc_sp = 2, vco_sp = 2;
    int n, lc, pre, post, ps;
    logic [31:0] v;
    logic [2:0] codes [5] = '{3'h1, 3'h6, 3'h7, 3'h4, 3'h0};

    rc_osc_postscaler_pll_ctrl rc_osc_postscaler_pll_ctrl_i (
        .REF_CLK(ref_clk), .RST_N(rst_n), .RC_TICK(rc_tick), .PRI_TICK(pri_tick),
        .VCO_TICK(vco_tick), .INIT_SRC(init_src), .SYS_TICK(sys_tick),
        .PLL_REF_TICK(pll_ref_tick), .RC_TRIM(rc_trim), .PLL_FB_FIELD(pll_fb_field),
        .PLL_LOCKED(pll_locked), .CUR_SOURCE(cur_source), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

    // 125 MHz reference
    always #4 ref_clk = ~ref_clk;

    // oscillator stand-ins: regular spacing so output periods are exact
    always @(posedge ref_clk)
    begin
        rc_tick <= rc_en && (cyc % rc_sp == 0);
        vco_tick <= vco_en && (cyc % vco_sp == 0);
        pri_tick <= pri_en;
    end

    // time-stamp the last two output pulses of each kind
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (sys_tick === 1'b1)
        begin
            sys_cnt <= sys_cnt + 1;
            sys_prev <= sys_last;
            sys_last <= cyc;
        end
        if (pll_ref_tick === 1'b1)
        begin
            ref_cnt <= ref_cnt + 1;
            ref_prev <= ref_last;
            ref_last <= cyc;
        end
    end

    // fixed-seed xorshift
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // rc postscale ratio; top code jumps to 256
    function automatic int ps_ratio(input int code);
        return (code == 7) ? 256 : (1 << code);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_ok, w_ok;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_ok = 0;
        w_ok = 0;
        while (!(aw_ok && w_ok))
        begin
            @(posedge ref_clk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge ref_clk);
        chk(bresp, er, "write response");
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk);
        chk(rdata, ed, "read data");
        chk(rresp, er, "read response");
    endtask

    // spacing between the 2nd and 3rd fresh pulses, old ratio flushed
    task automatic per(input bit r, input int exp, input string what);
        int c0;
        c0 = r ? ref_cnt : sys_cnt;
        wait ((r ? ref_cnt : sys_cnt) >= c0 + 3);
        @(negedge ref_clk);
        chk(r ? ref_last - ref_prev : sys_last - sys_prev, exp, what);
        @(posedge ref_clk);
    endtask

    // lock must stay low and the reference must stay silent
    task automatic hold0(input int cycles);
        int bad, c0;
        bad = 0;
        c0 = ref_cnt;
        repeat (cycles)
        begin
            @(posedge ref_clk);
            if (pll_locked !== 1'b0) bad++;
        end
        chk(bad, 0, "lock high");
        chk(ref_cnt - c0, 0, "reference pulses");
    endtask

    task automatic lockwait(output int cnt);
        cnt = 0;
        while (pll_locked !== 1'b1 && cnt < 2000)
        begin
            @(posedge ref_clk);
            cnt++;
        end
    endtask

    task automatic rst();
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    task give_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog, far beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        give_verdict;
    end

    initial
    begin
        rc_sp = 2 + rnd() % 2;
        vco_sp = 1 + rnd() % 2;
        rc_en = 1'b1;
        vco_en = 1'b1;
        // power-on straps, illegal code falls back to plain rc
        foreach (codes[i])
        begin
            init_src <= codes[i];
            rst();
            chk(cur_source, (codes[i] == 3'h4) ? 3'h0 : codes[i], "strap");
            chk(pll_fb_field, PLL_FEEDBACK_RST, "fb reset");
            case (codes[i])
                3'h1:
                begin
                    // default dividers: the bench stands for an input inside 4 to 8 MHz
                    lockwait(n);
                    chk(n >= 254 && n <= 262, 1, "default lock");
                    per(0, 4 * vco_sp, "default pll out");
                    per(1, 2 * rc_sp, "default pll ref");
                end
                3'h6: per(0, 16 * rc_sp, "div16");
                default: per(0, rc_sp, "plain rc");
            endcase
        end
        // register reset values and an unmapped slot
        chk(pll_locked, 1'b0, "lock at reset");
        rd(CLOCK_DIVISOR_CTRL_OFS, 32'h0040, RESP_OKAY);
        rd(PLL_FEEDBACK_DIVISOR_OFS, 32'h0030, RESP_OKAY);
        rd(RC_OSC_TUNING_OFS, 32'h0, RESP_OKAY);
        rd(LOCK_CYCLES_OFS, 32'h0100, RESP_OKAY);
        rd(5'h14, 32'h0, RESP_SLVERR);
        wr(5'h14, rnd(), RESP_SLVERR);
        // trim and feedback fields reach the analog side
        repeat (3)
        begin
            v = rnd() & 32'h3F;
            wr(RC_OSC_TUNING_OFS, v, RESP_OKAY);
            chk(rc_trim, v[5:0], "trim out");
            rd(RC_OSC_TUNING_OFS, v, RESP_OKAY);
            v = rnd() & 32'h1FF;
            wr(PLL_FEEDBACK_DIVISOR_OFS, v, RESP_OKAY);
            chk(pll_fb_field, v[8:0], "fb out");
            rd(PLL_FEEDBACK_DIVISOR_OFS, v, RESP_OKAY);
        end
        // a write with lane zero masked leaves the trim field alone
        v = rnd() & 32'h3F;
        wr(RC_OSC_TUNING_OFS, v, RESP_OKAY);
        wstrb <= 4'hE;
        wr(RC_OSC_TUNING_OFS, ~v, RESP_OKAY);
        wstrb <= 4'hF;
        chk(rc_trim, v[5:0], "masked lane");
        // every postscale code while running from the variable postscaler
        wr(OSC_CONTROL_REG_OFS, 32'h8700, RESP_OKAY);
        for (int p = 0; p < 8; p++)
        begin
            wr(CLOCK_DIVISOR_CTRL_OFS, p << RC_POSTSCALE_LSB, RESP_OKAY);
            per(0, ps_ratio(p) * rc_sp, "postscale");
        end
        wr(OSC_CONTROL_REG_OFS, 32'h8600, RESP_OKAY);
        per(0, 16 * rc_sp, "div16 ignores postscale");
        // dividers set outside pll mode, then switch into rc with pll
        lc = 2 + rnd() % 6;
        pre = rnd() % 32;
        post = rnd() % 4;
        ps = rnd() % 3;
        wr(LOCK_CYCLES_OFS, lc, RESP_OKAY);
        // dividers stand for a reference and oscillator inside their ranges
        wr(CLOCK_DIVISOR_CTRL_OFS, (ps << 8) | (post << 6) | pre, RESP_OKAY);
        wr(OSC_CONTROL_REG_OFS, 32'h8100, RESP_OKAY);
        chk(pll_locked, 1'b0, "lock after switch");
        lockwait(n);
        chk(n >= lc && n <= lc + 3, 1, "lock time");
        rd(OSC_CONTROL_REG_OFS, 32'h0121, RESP_OKAY);
        per(0, 2 * (post + 1) * vco_sp, "pll out");
        per(1, (pre + 2) * ps_ratio(ps) * rc_sp, "pll ref");
        // feedback changed on a bypass source, then back: lock restarts
        wr(OSC_CONTROL_REG_OFS, 32'h8000, RESP_OKAY);
        wr(PLL_FEEDBACK_DIVISOR_OFS, rnd() & 32'h1FF, RESP_OKAY);
        wr(OSC_CONTROL_REG_OFS, 32'h8100, RESP_OKAY);
        chk(pll_locked, 1'b0, "lock after fb change");
        lockwait(n);
        chk(n >= lc && n <= lc + 3, 1, "relock");
        // back to plain rc: lock stays low
        wr(OSC_CONTROL_REG_OFS, 32'h8000, RESP_OKAY);
        hold0(40);
        per(0, rc_sp, "plain rc again");
        wr(OSC_CONTROL_REG_OFS, 32'h8400, RESP_OKAY);
        chk(cur_source, SRC_RC, "illegal switch ignored");
        // primary held back by its startup count
        pri_en <= 1'b1;
        wr(OSC_CONTROL_REG_OFS, 32'h8200, RESP_OKAY);
        // let a last rc pulse from before the switch land first
        @(posedge ref_clk);
        n = sys_cnt;
        repeat (999) @(posedge ref_clk);
        chk(sys_cnt - n, 0, "startup hold");
        repeat (40) @(posedge ref_clk);
        chk(sys_cnt != n, 1, "startup release");
        per(0, 1, "primary");
        // primary with pll: lock waits for the startup count
        wr(OSC_CONTROL_REG_OFS, 32'h8000, RESP_OKAY);
        wr(OSC_CONTROL_REG_OFS, 32'h8300, RESP_OKAY);
        hold0(1000);
        lockwait(n);
        chk(n <= 60, 1, "primary lock");
        give_verdict;
    end
endmodule
